// ==== hdl/rrpe_encoder.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module rrpe_encoder #(
	parameter logic [7:0] RECEIVER_TYPE_CODE = 8'hA5 // Arbitrary value.
) (
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_we_i,
	input  wire logic        reg_re_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_data_i,
	input  wire logic        rx_first_i,
	input  wire logic        rx_last_i,
	output logic             tx_valid_o,
	output logic      [7:0]  tx_data_o,
	output logic             tx_first_o,
	output logic             tx_last_o,
	input  wire logic        tx_ready_i,
	input  wire logic        fix_done_i,
	input  wire logic [31:0] lat_i,
	input  wire logic [31:0] lon_i,
	input  wire logic [31:0] alt_hae_i,
	input  wire logic [31:0] alt_msl_i,
	input  wire logic [31:0] clk_bias_i,
	input  wire logic [31:0] tof_gps_i,
	input  wire logic [31:0] tof_utc_i,
	input  wire logic [11:0] sat_valid_i,
	output logic      [3:0]  sat_idx_o,
	input  wire logic [7:0]  sat_num_i,
	input  wire logic [31:0] sat_lvl_amu_i,
	input  wire logic [31:0] sat_lvl_dbhz_i,
	input  wire logic [31:0] osc_offset_i,
	input  wire logic        sat_time_valid_i,
	output logic             time_set_accept_o,
	input  wire logic        rtc_unavail_i,
	input  wire logic        almanac_stale_i,
	input  wire logic        health_sent_i,
	output logic             pos_xyz_en_o,
	output logic             vel_xyz_en_o,
	output logic             vel_enu_en_o,
	output logic             dbl_prec_o,
	output logic             superpkt_en_o,
	output logic             raw_meas_en_o,
	output logic             time_utc_o,
	output logic      [1:0]  pps_mode_o
);

	localparam int unsigned PW = rrpe_pkg::PAY_W;

	logic [7:0]  opt_q [4];
	logic [7:0]  shadow_q [3];
	logic [7:0]  rx_id_q;
	logic [2:0]  rx_cnt_q;
	logic [5:0]  pend_q, pend_d, set_v, clr_v;
	logic        boot_q;
	logic [159:0] fix_q;
	logic [7:0]  time_ans_q;
	logic [7:0]  stat1, stat2, stat1_last_q;
	rrpe_pkg::rrpe_state_e st_q;
	rrpe_pkg::rrpe_kind_e kind_q, grant;
	logic        grant_ok, adv, load;
	logic [PW-1:0] payload_q;
	logic [4:0]  len_q;
	logic [3:0]  sidx_q;
	logic [11:0] mask_q, scan_mask;
	logic [3:0]  scan_cnt, scan_next;
	logic        scan_found;
	logic        tx_valid_q, tx_first_q, tx_last_q;
	logic [7:0]  tx_data_q;
	logic [7:0]  reg_rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Host packet decode. A packet ends on its last byte; a one-byte packet
	// carries its identifier and its end in the same beat.
	logic       rx_end;
	logic [7:0] rx_id;
	logic       req_sig, req_id, req_osc, req_time, req_opt, cmd_opt;

	assign rx_end   = rx_valid_i && rx_last_i;
	assign rx_id    = rx_first_i ? rx_data_i : rx_id_q;
	assign req_sig  = rx_end && (rx_id == rrpe_pkg::REQ_SIG);
	assign req_id   = rx_end && (rx_id == rrpe_pkg::REQ_ID_A || rx_id == rrpe_pkg::REQ_ID_B);
	assign req_osc  = rx_end && (rx_id == rrpe_pkg::REQ_OSC);
	assign req_time = rx_end && (rx_id == rrpe_pkg::REQ_TIME);
	assign req_opt  = rx_end && (rx_id == rrpe_pkg::CMD_OPT);
	assign cmd_opt  = req_opt && !rx_first_i && (rx_cnt_q == 3'h3);

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			rx_id_q  <= 8'h00;
			rx_cnt_q <= 3'h0;
		end else if (rx_valid_i) begin
			if (rx_first_i) begin
				rx_id_q  <= rx_data_i;
				rx_cnt_q <= 3'h0;
			end else if (rx_cnt_q != 3'h7) begin
				rx_cnt_q <= rx_cnt_q + 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rx_valid_i && !rx_first_i && rx_cnt_q < 3'h3) begin
			shadow_q[rx_cnt_q[1:0]] <= rx_data_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Options. The command and the register port write the same layout; the
	// command wins when both land together, since the host link is the owner.
	localparam logic [7:0] OPT_MASK [4] = '{rrpe_pkg::OPT0_MASK, rrpe_pkg::OPT1_MASK,
		rrpe_pkg::OPT2_MASK, rrpe_pkg::OPT3_MASK};
	localparam logic [7:0] OPT_RST [4] = '{rrpe_pkg::OPT0_RST, rrpe_pkg::OPT1_RST,
		rrpe_pkg::OPT2_RST, rrpe_pkg::OPT3_RST};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_opt
			logic [7:0] cmd_byte;
			assign cmd_byte = (g == 3) ? rx_data_i : shadow_q[g % 3];
			always_ff @(posedge core_clk_i) begin
				if (srst_i) begin
					opt_q[g] <= OPT_RST[g];
				end else if (cmd_opt) begin
					opt_q[g] <= cmd_byte & OPT_MASK[g];
				end else if (reg_we_i && reg_addr_i == 4'(g)) begin
					opt_q[g] <= reg_wdata_i & OPT_MASK[g];
				end
			end
		end
	endgenerate

	// Superpacket choice itself is made elsewhere by the host's own command.
	assign pos_xyz_en_o  = opt_q[0][rrpe_pkg::OPT0_XYZ];
	assign dbl_prec_o    = opt_q[0][rrpe_pkg::OPT0_DOUBLE];
	assign superpkt_en_o = opt_q[0][rrpe_pkg::OPT0_SUPER];
	assign vel_xyz_en_o  = opt_q[1][rrpe_pkg::OPT1_VXYZ];
	assign vel_enu_en_o  = opt_q[1][rrpe_pkg::OPT1_VENU];
	assign time_utc_o    = opt_q[2][rrpe_pkg::OPT2_UTC];
	assign pps_mode_o    = opt_q[2][rrpe_pkg::OPT2_PPS_LO +: 2];
	assign raw_meas_en_o = opt_q[3][rrpe_pkg::OPT3_RAW];

	////////////////////////////////////////////////////////////////////////////
	// Status bytes and report triggers.
	logic sig_en, fix_sel, fix_take;

	always_comb begin
		stat1 = 8'h00;
		stat2 = 8'h00;
		stat1[rrpe_pkg::ST1_RTC]   = rtc_unavail_i;
		stat1[rrpe_pkg::ST1_ALM]   = almanac_stale_i;
		stat2[rrpe_pkg::ST2_SUPER] = 1'b1;
	end

	assign sig_en  = opt_q[3][rrpe_pkg::OPT3_SIGLVL];
	assign fix_sel = opt_q[0][rrpe_pkg::OPT0_LLA] && !opt_q[0][rrpe_pkg::OPT0_DOUBLE];
	// A fresh fix is not snapshot while the previous one is being sent.
	assign fix_take = (boot_q || (fix_done_i && fix_sel)) &&
		!(st_q == rrpe_pkg::ST_BODY && kind_q == rrpe_pkg::K_FIX);

	always_comb begin
		set_v = 6'h00;
		set_v[rrpe_pkg::K_FIX]  = fix_take;
		set_v[rrpe_pkg::K_ID]   = req_id || health_sent_i || (stat1 != stat1_last_q);
		set_v[rrpe_pkg::K_TIME] = req_time;
		set_v[rrpe_pkg::K_OSC]  = req_osc;
		set_v[rrpe_pkg::K_OPT]  = req_opt;
		set_v[rrpe_pkg::K_SIG]  = req_sig && sig_en;
		clr_v = 6'h00;
		clr_v[grant] = load;
		clr_v[rrpe_pkg::K_SIG] = clr_v[rrpe_pkg::K_SIG] || !sig_en;
		pend_d = (pend_q & ~clr_v) | set_v;
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			pend_q       <= 6'h00;
			boot_q       <= 1'b1;
			stat1_last_q <= 8'h00;
		end else begin
			pend_q       <= pend_d;
			boot_q       <= 1'b0;
			stat1_last_q <= stat1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			fix_q <= 160'h0;
		end else if (fix_take) begin
			fix_q[159:128] <= lat_i;
			fix_q[127:96]  <= lon_i;
			fix_q[95:64]   <= opt_q[0][rrpe_pkg::OPT0_ALT_MSL] ? alt_msl_i : alt_hae_i;
			fix_q[63:32]   <= clk_bias_i;
			fix_q[31:0]    <= opt_q[2][rrpe_pkg::OPT2_UTC] ? tof_utc_i : tof_gps_i;
			if (boot_q) begin
				fix_q[rrpe_pkg::FLT_SIGN] <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			time_ans_q        <= rrpe_pkg::ASCII_YES;
			time_set_accept_o <= 1'b0;
		end else begin
			time_set_accept_o <= req_time && !sat_time_valid_i;
			if (req_time) begin
				time_ans_q <= sat_time_valid_i ? rrpe_pkg::ASCII_NO : rrpe_pkg::ASCII_YES;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Arbitration and byte sequencing. The output stage is one register deep
	// and moves whenever it is empty or the host side takes the byte.
	always_comb begin
		grant    = rrpe_pkg::K_SIG;
		grant_ok = 1'b0;
		// A level request left over from before the option was cleared must not start.
		for (int i = 5; i >= 0; i--) begin
			if (pend_q[i] && (sig_en || i != int'(rrpe_pkg::K_SIG))) begin
				grant    = rrpe_pkg::rrpe_kind_e'(3'(i));
				grant_ok = 1'b1;
			end
		end
	end

	assign adv       = !tx_valid_q || tx_ready_i;
	assign load      = adv && grant_ok && st_q == rrpe_pkg::ST_IDLE;
	assign scan_mask = (st_q == rrpe_pkg::ST_IDLE) ? sat_valid_i : mask_q;
	assign sat_idx_o = scan_next;

	rrpe_sat_scan u_scan (
		.mask_i  (scan_mask),
		.start_i (sidx_q),
		.count_o (scan_cnt),
		.next_o  (scan_next),
		.found_o (scan_found)
	);

	logic [31:0] sat_lvl;
	logic        body_end;
	assign sat_lvl  = opt_q[3][rrpe_pkg::OPT3_DBHZ] ? sat_lvl_dbhz_i : sat_lvl_amu_i;
	assign body_end = (len_q == 5'h01) && !(kind_q == rrpe_pkg::K_SIG && scan_found);

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			st_q       <= rrpe_pkg::ST_IDLE;
			kind_q     <= rrpe_pkg::K_FIX;
			payload_q  <= '0;
			len_q      <= 5'h00;
			sidx_q     <= 4'h0;
			mask_q     <= 12'h000;
			tx_valid_q <= 1'b0;
			tx_data_q  <= 8'h00;
			tx_first_q <= 1'b0;
			tx_last_q  <= 1'b0;
		end else if (adv) begin
			unique case (st_q)
				rrpe_pkg::ST_IDLE: begin
					tx_valid_q <= grant_ok;
					tx_first_q <= grant_ok;
					tx_last_q  <= 1'b0;
					if (grant_ok) begin
						kind_q <= grant;
						st_q   <= rrpe_pkg::ST_BODY;
						sidx_q <= 4'h0;
						mask_q <= sat_valid_i;
						unique case (grant)
							rrpe_pkg::K_FIX: begin
								tx_data_q <= rrpe_pkg::RPT_FIX;
								payload_q <= fix_q;
								len_q     <= rrpe_pkg::LEN_FIX;
							end
							rrpe_pkg::K_ID: begin
								tx_data_q <= rrpe_pkg::RPT_ID;
								payload_q <= {RECEIVER_TYPE_CODE, stat1, stat2, 136'h0};
								len_q     <= rrpe_pkg::LEN_ID;
							end
							rrpe_pkg::K_TIME: begin
								tx_data_q <= rrpe_pkg::RPT_TIME;
								payload_q <= {time_ans_q, 152'h0};
								len_q     <= rrpe_pkg::LEN_BYTE;
							end
							rrpe_pkg::K_OSC: begin
								tx_data_q <= rrpe_pkg::RPT_OSC;
								payload_q <= {osc_offset_i, 128'h0};
								len_q     <= rrpe_pkg::LEN_WORD;
							end
							rrpe_pkg::K_OPT: begin
								tx_data_q <= rrpe_pkg::RPT_OPT;
								payload_q <= {opt_q[0], opt_q[1], opt_q[2], opt_q[3], 128'h0};
								len_q     <= rrpe_pkg::LEN_WORD;
							end
							default: begin
								tx_data_q <= rrpe_pkg::RPT_SIG;
								payload_q <= {4'h0, scan_cnt, 152'h0};
								len_q     <= rrpe_pkg::LEN_BYTE;
							end
						endcase
					end
				end
				rrpe_pkg::ST_BODY: begin
					tx_valid_q <= 1'b1;
					tx_first_q <= 1'b0;
					tx_data_q  <= payload_q[PW-1 -: 8];
					tx_last_q  <= body_end;
					if (body_end) begin
						st_q <= rrpe_pkg::ST_IDLE;
					end else if (len_q == 5'h01) begin
						// Level sign and magnitude are passed through untouched.
						payload_q <= {sat_num_i, sat_lvl, 120'h0};
						len_q     <= rrpe_pkg::LEN_SAT;
						sidx_q    <= scan_next + 4'h1;
					end else begin
						payload_q <= {payload_q[PW-9:0], 8'h00};
						len_q     <= len_q - 5'h01;
					end
				end
			endcase
		end
	end

	assign tx_valid_o = tx_valid_q;
	assign tx_data_o  = tx_data_q;
	assign tx_first_o = tx_first_q;
	assign tx_last_o  = tx_last_q;

	////////////////////////////////////////////////////////////////////////////
	// Register port: read data follow the read strobe by one cycle.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_re_i) begin
			unique case (reg_addr_i)
				rrpe_pkg::REG_OPT0:   reg_rdata_q <= opt_q[0];
				rrpe_pkg::REG_OPT1:   reg_rdata_q <= opt_q[1];
				rrpe_pkg::REG_OPT2:   reg_rdata_q <= opt_q[2];
				rrpe_pkg::REG_OPT3:   reg_rdata_q <= opt_q[3];
				rrpe_pkg::REG_STAT1:  reg_rdata_q <= stat1;
				rrpe_pkg::REG_STAT2:  reg_rdata_q <= stat2;
				rrpe_pkg::REG_RXTYPE: reg_rdata_q <= RECEIVER_TYPE_CODE;
				rrpe_pkg::REG_PEND:   reg_rdata_q <= {2'h0, pend_q};
				default:              reg_rdata_q <= 8'h00;
			endcase
		end
	end
	assign reg_rdata_o = reg_rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks. The body counter counts accepted bytes after the identifier.
	logic [4:0] hcnt_q;
	logic       acc;
	assign acc = tx_valid_q && tx_ready_i;
	always_ff @(posedge core_clk_i) begin
		if (srst_i || (acc && tx_first_q)) begin
			hcnt_q <= 5'h00;
		end else if (acc) begin
			hcnt_q <= hcnt_q + 5'h01;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	a_sig_gated: assert property (load && grant == rrpe_pkg::K_SIG |-> sig_en)
		else $error("signal report started while disabled");
	a_sig_pairs: assert property (st_q == rrpe_pkg::ST_BODY |-> sidx_q <= 4'(rrpe_pkg::MAX_SATS))
		else $error("satellite index past table");
	a_fix_len: assert property (acc && tx_last_q && kind_q == rrpe_pkg::K_FIX |-> hcnt_q == 5'h13)
		else $error("fix report length wrong");
	a_id_len: assert property (acc && tx_last_q && kind_q == rrpe_pkg::K_ID |-> hcnt_q == 5'h02)
		else $error("identity report length wrong");
	// The reset edge itself is excluded: boot_q is still set there but nothing is queued yet.
	a_boot_fix: assert property (
		boot_q && !srst_i |=> pend_q[rrpe_pkg::K_FIX] && fix_q[rrpe_pkg::FLT_SIGN])
		else $error("start-up fix not negative or not queued");
	a_fix_gate: assert property (
		fix_done_i && !fix_sel && !boot_q && !pend_q[rrpe_pkg::K_FIX]
		|=> !pend_q[rrpe_pkg::K_FIX])
		else $error("fix report queued while not selected");
	a_alt_select: assert property (
		fix_take && !boot_q |=> fix_q[95:64] ==
		($past(opt_q[0][rrpe_pkg::OPT0_ALT_MSL]) ? $past(alt_msl_i) : $past(alt_hae_i)))
		else $error("altitude reference wrong");
	a_time_answer: assert property (
		req_time |=> pend_q[rrpe_pkg::K_TIME] &&
		time_ans_q == ($past(sat_time_valid_i) ? rrpe_pkg::ASCII_NO : rrpe_pkg::ASCII_YES))
		else $error("set-time answer wrong");
	a_health_id: assert property (
		health_sent_i |=> pend_q[rrpe_pkg::K_ID] ||
		(st_q == rrpe_pkg::ST_BODY && kind_q == rrpe_pkg::K_ID))
		else $error("identity report not queued with health");
	// The sink may stall, so the last body byte is allowed a window rather than a fixed cycle.
	a_osc_word: assert property (
		load && grant == rrpe_pkg::K_OSC |=>
		(payload_q[PW-1 -: 32] == $past(osc_offset_i)) ##[4:60] tx_last_q)
		else $error("oscillator report wrong");
	a_opt_resv: assert property (
		(opt_q[0] & ~rrpe_pkg::OPT0_MASK) == 8'h00 &&
		(opt_q[1] & ~rrpe_pkg::OPT1_MASK) == 8'h00)
		else $error("reserved option bits set");

	c_sig_pairs: cover property (acc && tx_last_q && kind_q == rrpe_pkg::K_SIG && hcnt_q > 5'h00);
	c_fix_sent:  cover property (acc && tx_last_q && kind_q == rrpe_pkg::K_FIX);
	c_time_no:   cover property (req_time && sat_time_valid_i);
	c_opt_cmd:   cover property (cmd_opt);

endmodule : rrpe_encoder

// ==== inc/rrpe_pkg.sv ====
package rrpe_pkg;

	// Report identifiers sent to the host.
	localparam logic [7:0] RPT_SIG  = 8'h47;
	localparam logic [7:0] RPT_FIX  = 8'h4A;
	localparam logic [7:0] RPT_ID   = 8'h4B;
	localparam logic [7:0] RPT_OSC  = 8'h4D;
	localparam logic [7:0] RPT_TIME = 8'h4E;
	localparam logic [7:0] RPT_OPT  = 8'h55;

	// Request and command identifiers received from the host.
	localparam logic [7:0] REQ_SIG  = 8'h27;
	localparam logic [7:0] REQ_ID_A = 8'h25;
	localparam logic [7:0] REQ_ID_B = 8'h26;
	localparam logic [7:0] REQ_OSC  = 8'h2D;
	localparam logic [7:0] REQ_TIME = 8'h2E;
	localparam logic [7:0] CMD_OPT  = 8'h35;

	localparam logic [7:0] ASCII_YES = 8'h59;
	localparam logic [7:0] ASCII_NO  = 8'h4E;

	localparam int unsigned MAX_SATS  = 12;
	localparam int unsigned SAT_IDX_W = 4;
	localparam int unsigned PAY_W     = 160;
	localparam int unsigned FLT_SIGN  = 31;

	// Body lengths in bytes.
	localparam logic [4:0] LEN_FIX  = 5'h14;
	localparam logic [4:0] LEN_ID   = 5'h03;
	localparam logic [4:0] LEN_WORD = 5'h04;
	localparam logic [4:0] LEN_BYTE = 5'h01;
	localparam logic [4:0] LEN_SAT  = 5'h05;

	// Option bit positions.
	localparam int unsigned OPT0_XYZ     = 0;
	localparam int unsigned OPT0_LLA     = 1;
	localparam int unsigned OPT0_ALT_MSL = 2;
	localparam int unsigned OPT0_DOUBLE  = 4;
	localparam int unsigned OPT0_SUPER   = 5;
	localparam int unsigned OPT1_VXYZ    = 0;
	localparam int unsigned OPT1_VENU    = 1;
	localparam int unsigned OPT2_UTC     = 0;
	localparam int unsigned OPT2_PPS_LO  = 5;
	localparam int unsigned OPT3_RAW     = 0;
	localparam int unsigned OPT3_DBHZ    = 3;
	localparam int unsigned OPT3_SIGLVL  = 5;

	// Writable bits of each options byte; reserved bits hold zero.
	localparam logic [7:0] OPT0_MASK = 8'h37;
	localparam logic [7:0] OPT1_MASK = 8'h03;
	localparam logic [7:0] OPT2_MASK = 8'h61;
	localparam logic [7:0] OPT3_MASK = 8'h29;
	localparam logic [7:0] OPT0_RST  = 8'h02;
	localparam logic [7:0] OPT1_RST  = 8'h00;
	localparam logic [7:0] OPT2_RST  = 8'h00;
	localparam logic [7:0] OPT3_RST  = 8'h20;

	// Status byte bit positions.
	localparam int unsigned ST1_RTC   = 1;
	localparam int unsigned ST1_ALM   = 3;
	localparam int unsigned ST2_SUPER = 0;

	// Register port map.
	localparam logic [3:0] REG_OPT0   = 4'h0;
	localparam logic [3:0] REG_OPT1   = 4'h1;
	localparam logic [3:0] REG_OPT2   = 4'h2;
	localparam logic [3:0] REG_OPT3   = 4'h3;
	localparam logic [3:0] REG_STAT1  = 4'h4;
	localparam logic [3:0] REG_STAT2  = 4'h5;
	localparam logic [3:0] REG_RXTYPE = 4'h6;
	localparam logic [3:0] REG_PEND   = 4'h7;

	// Report kinds; lower code wins arbitration.
	typedef enum logic [2:0] {
		K_FIX  = 3'b000,
		K_ID   = 3'b001,
		K_TIME = 3'b010,
		K_OSC  = 3'b011,
		K_OPT  = 3'b100,
		K_SIG  = 3'b101
	} rrpe_kind_e;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_BODY = 1'b1
	} rrpe_state_e;

endpackage : rrpe_pkg

// ==== hdl/rrpe_sat_scan.sv ====
`timescale 1ns/1ps
module rrpe_sat_scan (
	input  wire logic [11:0] mask_i,
	input  wire logic [3:0]  start_i,
	output logic      [3:0]  count_o,
	output logic      [3:0]  next_o,
	output logic             found_o
);

	logic [11:0] hit;

	genvar g;
	generate
		for (g = 0; g < 12; g++) begin : g_hit
			assign hit[g] = mask_i[g] && (4'(g) >= start_i);
		end
	endgenerate

	always_comb begin
		count_o = 4'h0;
		next_o  = 4'h0;
		found_o = 1'b0;
		for (int i = 11; i >= 0; i--) begin
			count_o = count_o + {3'h0, mask_i[i]};
			if (hit[i]) begin
				next_o  = 4'(i);
				found_o = 1'b1;
			end
		end
	end

endmodule : rrpe_sat_scan

// ==== verification/rrpe_host_model.sv ====
`timescale 1ns/1ps
module rrpe_host_model (
	input  wire logic       clk_i,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_first_i,
	input  wire logic       tx_last_i,
	output logic            tx_ready_o,
	output logic            rx_valid_o,
	output logic      [7:0] rx_data_o,
	output logic            rx_first_o,
	output logic            rx_last_o
);
	logic [9:0] q [$];

	initial begin
		tx_ready_o = 1'b1;
		rx_valid_o = 1'b0;
		rx_data_o  = 8'h00;
		rx_first_o = 1'b0;
		rx_last_o  = 1'b0;
	end

	////////////////////////////////////////
	// The sink stalls at random, so a byte that is not held until taken shows up.
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o)
			q.push_back({tx_first_i, tx_last_i, tx_data_i});
		tx_ready_o <= ($urandom_range(3) != 0);
	end

	task automatic send(input logic [7:0] b [$]);
		foreach (b[k]) begin
			@(posedge clk_i);
			rx_valid_o <= 1'b1;
			rx_data_o  <= b[k];
			rx_first_o <= (k == 0);
			rx_last_o  <= (k == b.size() - 1);
		end
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_first_o <= 1'b0;
		rx_last_o  <= 1'b0;
		rx_data_o  <= ~b[b.size() - 1];
	endtask : send
endmodule : rrpe_host_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	localparam logic [7:0] M [4] = '{8'h37, 8'h03, 8'h61, 8'h29};
	localparam logic [7:0] RV [7] = '{8'h02, 8'h00, 8'h00, 8'h20, 8'h00, 8'h01, 8'hA5};
	logic        clk = 1'b0, srst = 1'b1, we = 1'b0, re = 1'b0, fix = 1'b0;
	logic        tv = 1'b0, rtc = 1'b0, alm = 1'b0, hs = 1'b0, tsa;
	logic        rxv, rxf, rxl, txv, txf, txl, txr;
	logic [3:0]  addr = 4'h0, sidx;
	logic [7:0]  wd = 8'h00, rdata, txd, rxd;
	wire  [8:0]  ov;
	logic [11:0] sv = 12'h000;
	logic [31:0] w [10] = '{default: 32'h0};
	logic [31:0] f [5];
	logic [7:0]  o [4];
	logic [7:0]  e [$];
	int          mismatches = 0, total_checks = 0;

	rrpe_encoder DUT (.core_clk_i(clk), .srst_i(srst), .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .rx_valid_i(rxv), .rx_data_i(rxd),
		.rx_first_i(rxf), .rx_last_i(rxl), .tx_valid_o(txv), .tx_data_o(txd), .tx_first_o(txf),
		.tx_last_o(txl), .tx_ready_i(txr), .fix_done_i(fix), .lat_i(w[0]), .lon_i(w[1]),
		.alt_hae_i(w[2]), .alt_msl_i(w[3]), .clk_bias_i(w[4]), .tof_gps_i(w[5]),
		.tof_utc_i(w[6]), .sat_valid_i(sv), .sat_idx_o(sidx), .sat_num_i({4'h1, sidx}),
		.sat_lvl_amu_i({w[8][31:4], sidx}), .sat_lvl_dbhz_i({w[9][31:4], sidx}),
		.osc_offset_i(w[7]), .sat_time_valid_i(tv), .time_set_accept_o(tsa),
		.rtc_unavail_i(rtc), .almanac_stale_i(alm), .health_sent_i(hs), .pos_xyz_en_o(ov[8]),
		.vel_xyz_en_o(ov[7]), .vel_enu_en_o(ov[6]), .dbl_prec_o(ov[5]), .superpkt_en_o(ov[4]),
		.raw_meas_en_o(ov[3]), .time_utc_o(ov[2]), .pps_mode_o(ov[1:0]));

	rrpe_host_model h (.clk_i(clk), .tx_valid_i(txv), .tx_data_i(txd), .tx_first_i(txf),
		.tx_last_i(txl), .tx_ready_o(txr), .rx_valid_o(rxv), .rx_data_o(rxd),
		.rx_first_o(rxf), .rx_last_o(rxl));

	initial begin
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, s, x);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	// Waits out a quiet spell after the bytes arrive, so an extra report is caught too.
	task automatic take(input int n);
		int k = 0;
		while (h.q.size() < n) begin
			@(posedge clk);
			k++;
			if (k > 600) begin
				mismatches++;
				report_and_stop();
			end
		end
		repeat (40) @(posedge clk);
		chk(h.q.size(), n);
	endtask : take

	task automatic pkt();
		take(e.size());
		foreach (e[k]) chk(h.q[k], {k == 0, k == e.size() - 1, e[k]});
		e.delete();
		h.q.delete();
	endtask : pkt

	task automatic pw(input logic [31:0] v);
		for (int k = 3; k >= 0; k--) e.push_back(v[8*k+:8]);
	endtask : pw

	task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd   <= d;
		we   <= wr;
		re   <= !wr;
		@(posedge clk);
		we   <= 1'b0;
		re   <= 1'b0;
		#1;
	endtask : acc

	task automatic idp();
		e = '{8'h4B, 8'hA5, {4'h0, alm, 1'b0, rtc, 1'b0}, 8'h01};
		pkt();
	endtask : idp

	initial begin
		void'($urandom(7));
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		take(21);
		chk(h.q[0], 10'h24A);
		chk(h.q[17][7], 1'b1);
		h.q.delete();
		acc(1'b1, 4'h4, 8'hFF);
		acc(1'b1, 4'h9, 8'hFF);
		foreach (RV[a]) begin
			acc(1'b0, a[3:0], 8'h00);
			chk(rdata, RV[a]);
		end
		acc(1'b0, 4'h9, 8'h00);
		chk(rdata, 8'h00);
		@(posedge clk);
		rtc <= 1'b1;
		alm <= 1'($urandom);
		@(posedge clk);
		idp();
		h.send('{8'h25});
		idp();
		h.send('{8'h26});
		idp();
		@(posedge clk);
		hs <= 1'b1;
		@(posedge clk);
		hs <= 1'b0;
		idp();
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			tv <= i[0];
			h.send('{8'h2E});
			#1;
			chk(tsa, !i[0]);
			e = '{8'h4E, i[0] ? 8'h4E : 8'h59};
			pkt();
		end
		@(posedge clk);
		foreach (w[k]) w[k] <= $urandom;
		h.send('{8'h2D});
		e = '{8'h4D};
		pw(w[7]);
		pkt();
		for (int i = 0; i < 6; i++) begin
			foreach (o[k]) o[k] = 8'($urandom);
			o[0][1] = (i != 4);
			o[0][4] = (i == 3);
			o[3][5] = i[1];
			if (i[0])
				h.send('{8'h35, o[0], o[1], o[2], o[3]});
			else
				foreach (o[k]) acc(1'b1, k[3:0], o[k]);
			foreach (o[k]) o[k] &= M[k];
			if (i[0])
				e = '{8'h55, o[0], o[1], o[2], o[3]};
			pkt();
			foreach (o[k]) begin
				acc(1'b0, k[3:0], 8'h00);
				chk(rdata, o[k]);
			end
			chk(ov, {o[0][0], o[1][0], o[1][1], o[0][4], o[0][5], o[3][0], o[2][0], o[2][6:5]});
			@(posedge clk);
			foreach (w[k]) w[k] <= $urandom;
			fix <= 1'b1;
			@(posedge clk);
			fix <= 1'b0;
			f = '{w[0], w[1], o[0][2] ? w[3] : w[2], w[4], o[2][0] ? w[6] : w[5]};
			if (o[0][1] && !o[0][4])
				e = '{8'h4A};
			if (o[0][1] && !o[0][4])
				foreach (f[k]) pw(f[k]);
			pkt();
			@(posedge clk);
			sv <= (i == 2) ? 12'hFFF : 12'($urandom);
			h.send('{8'h27});
			if (o[3][5])
				e = '{8'h47, 8'($countones(sv))};
			for (int s = 0; s < 12; s++) begin
				if (o[3][5] && sv[s]) begin
					e.push_back({4'h1, 4'(s)});
					pw({w[o[3][3] ? 9 : 8][31:4], 4'(s)});
				end
			end
			pkt();
		end
		report_and_stop();
	end
endmodule : testbench
